// [lpc_irq_pkg.sv]
// constants, states and carrier types of the locality interrupt unit
`default_nettype none
package lpc_irq_pkg;
  // host link field values
  localparam logic [3:0] LOC_START     = 4'h5;
  localparam logic [3:0] IO_START      = 4'h0;
  localparam logic [3:0] CYC_IO_READ   = 4'h0;
  localparam logic [3:0] CYC_IO_WRITE  = 4'h2;
  localparam logic [3:0] SYNC_READY    = 4'h0;
  localparam logic [3:0] TAR_IDLE      = 4'hF;
  localparam logic [7:0] UNMAPPED_READ = 8'hFF;

  // locality space: address bits 15:12 select the locality
  localparam int         NUM_LOCALITIES = 5;
  localparam int         LOC_FIELD_LSB  = 12;
  localparam logic [11:0] OFS_OWNERSHIP  = 12'h000;
  localparam logic [11:0] OFS_IRQ_ENABLE = 12'h008;
  localparam logic [11:0] OFS_IRQ_EN_TOP = 12'h00B;
  localparam logic [11:0] OFS_IRQ_VECTOR = 12'h00C;
  localparam logic [11:0] OFS_IRQ_CAUSE  = 12'h010;

  // interrupt_enable fields (master enable is bit 7 of the top byte)
  localparam int EN_CMD_IDLE  = 7;
  localparam int TRIG_HI      = 4;
  localparam int TRIG_LO      = 3;
  localparam int EN_OWNER_SW  = 2;
  localparam int EN_STATUS_OK = 1;
  localparam int EN_RESPONSE  = 0;
  localparam int MASTER_BIT   = 7;

  // interrupt_cause_flags fields
  localparam int CAUSE_CMD_IDLE  = 7;
  localparam int CAUSE_OWNER_SW  = 2;
  localparam int CAUSE_STATUS_OK = 1;
  localparam int CAUSE_RESPONSE  = 0;
  localparam logic [7:0] CAUSE_MASK = 8'h87;

  // ownership_register fields
  localparam int OWN_REQUEST = 1;
  localparam int OWN_PENDING = 2;
  localparam int OWN_ACTIVE  = 5;

  // reset values
  localparam logic       ENABLE_RESET  = 1'b0;
  localparam logic [1:0] TRIGGER_RESET = 2'h1;
  localparam logic [3:0] VECTOR_RESET  = 4'h0;
  localparam logic [7:0] CAUSE_RESET   = 8'h00;

  // serial interrupt frame timing, in clocks
  localparam int SIRQ_START_MIN = 4;
  localparam int SIRQ_IRQ_SLOTS = 16;

  // legacy port window
  localparam logic [15:0] LEGACY_BASE_DEFAULT = 16'h004E;
  localparam int          LEGACY_PORTS        = 2;

  typedef enum logic [1:0] {
    TRIG_HIGH_LEVEL, TRIG_LOW_LEVEL, TRIG_RISE_EDGE, TRIG_FALL_EDGE
  } trigger_e;

  typedef enum logic [3:0] {
    LPC_IDLE, LPC_START, LPC_ADDR, LPC_WDATA,
    LPC_HTAR, LPC_SYNC, LPC_RDATA, LPC_DTAR
  } lpc_state_e;

  typedef enum logic [1:0] {
    PH_SAMPLE, PH_RECOVER, PH_TURN
  } sirq_phase_e;

  typedef struct packed {
    logic [3:0] serialIrqChannel;
    trigger_e   triggerTypeSel;
  } irq_cfg_s;

  typedef struct packed {
    logic        write;
    logic [15:0] addr;
    logic [7:0]  data;
  } legacy_access_s;
endpackage : lpc_irq_pkg
`default_nettype wire

// [serial_irq_slot.sv]
// serial interrupt frame follower that drives one interrupt slot
`default_nettype none
`timescale 1ns/1ns
module serial_irq_slot (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 serirqIn,
  output var  logic                 serirqOut,
  output var  logic                 serirqOe,
  input  wire lpc_irq_pkg::irq_cfg_s cfg,
  input  wire logic                 irqActive
);
  logic [3:0]               lowCnt_reg;
  logic                     active_reg;
  logic                     active_next;
  lpc_irq_pkg::sirq_phase_e phase_reg;
  lpc_irq_pkg::sirq_phase_e phase_next;
  logic [4:0]               slot_reg;
  logic [4:0]               slot_next;
  logic                     frameRise;
  logic                     irqLow;
  logic                     mySlot;
  logic                     oeNext;

  // only a start frame long enough counts; stop frames are shorter
  assign frameRise = serirqIn &&
    (lowCnt_reg >= 4'(lpc_irq_pkg::SIRQ_START_MIN));

  // high level and rising edge idle low; low level and falling idle high
  assign irqLow = (cfg.triggerTypeSel == lpc_irq_pkg::TRIG_LOW_LEVEL ||
                   cfg.triggerTypeSel == lpc_irq_pkg::TRIG_FALL_EDGE)
                  ? irqActive : !irqActive;

  // channel zero never matches, so the line stays released
  assign mySlot = active_next &&
    cfg.serialIrqChannel != 4'h0 &&
    slot_next == {1'b0, cfg.serialIrqChannel};

  always_comb begin
    active_next = active_reg;
    phase_next  = phase_reg;
    slot_next   = slot_reg;
    if (frameRise) begin
      active_next = 1'b1;
      phase_next  = lpc_irq_pkg::PH_TURN;
      slot_next   = 5'h1F;
    end else if (active_reg) begin
      case (phase_reg)
        lpc_irq_pkg::PH_SAMPLE:  phase_next = lpc_irq_pkg::PH_RECOVER;
        lpc_irq_pkg::PH_RECOVER: phase_next = lpc_irq_pkg::PH_TURN;
        default: begin
          phase_next = lpc_irq_pkg::PH_SAMPLE;
          slot_next  = slot_reg + 5'h01;
          if (slot_next == 5'(lpc_irq_pkg::SIRQ_IRQ_SLOTS)) begin
            active_next = 1'b0;
          end
        end
      endcase
    end
  end

  // drive low in the sample phase, restore high in recovery
  always_comb begin
    oeNext = 1'b0;
    if (mySlot && phase_next == lpc_irq_pkg::PH_SAMPLE) begin
      oeNext = irqLow;
    end else if (mySlot && phase_next == lpc_irq_pkg::PH_RECOVER) begin
      oeNext = serirqOe;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lowCnt_reg <= 4'h0;
      active_reg <= 1'b0;
      phase_reg  <= lpc_irq_pkg::PH_TURN;
      slot_reg   <= 5'h00;
      serirqOe   <= 1'b0;
      serirqOut  <= 1'b1;
    end else begin
      if (serirqIn || serirqOe) begin
        lowCnt_reg <= 4'h0;
      end else if (lowCnt_reg != 4'hF) begin
        lowCnt_reg <= lowCnt_reg + 4'h1;
      end
      active_reg <= active_next;
      phase_reg  <= phase_next;
      slot_reg   <= slot_next;
      serirqOe   <= oeNext;
      serirqOut  <= (phase_next == lpc_irq_pkg::PH_RECOVER);
    end
  end
endmodule : serial_irq_slot
`default_nettype wire

// [lpc_locality_interrupt_unit.sv]
// host link slave with locality decode, ownership and interrupt registers
`default_nettype none
`timescale 1ns/1ns
// Behaviour
// - separate reset-zero cause enables; bits 6:5 zero
// - trigger field bits 4:3, four schemes, reset 01
// - command-idle rise sets cause bit 7
// - causes reset zero; write one clears, EOI
// - delayed ownership grant sets owner-switch cause
// - request with no owner granted, no cause
// - status-ok rise sets cause bit 1
// - response rise with status-ok sets bit 0
// - channel field 3:0; zero releases the line
// - channel bits 7:4 read zero, writes ignored
// - legacy ports optional, kept by parameter
// - legacy cycles accepted only with no owner
// - locality start marks ordinary cycles as ours
// - locality write nibble order as I/O write
// - locality read nibble order as I/O read
// - master enable low or changing blocks interrupts
// - new cause with none outstanding asserts interrupt
// - no new interrupt until EOI; leftovers re-signal
// - one shared interrupt setting for all localities
module lpc_locality_interrupt_unit #(
  parameter logic        LEGACY_EN   = 1'b1,
  parameter logic [15:0] LEGACY_BASE = lpc_irq_pkg::LEGACY_BASE_DEFAULT
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       lframeN,
  input  wire logic [3:0]                 ladIn,
  output var  logic [3:0]                 ladOut,
  output var  logic                       ladOe,
  input  wire logic                       serirqIn,
  output var  logic                       serirqOut,
  output var  logic                       serirqOe,
  input  wire logic                       cmdIdleFlag,
  input  wire logic                       statusOkFlag,
  input  wire logic                       responseReadyFlag,
  output var  logic                       ownerValid,
  output var  logic [2:0]                 currentOwner,
  output var  logic                       irqPending,
  output var  logic                       legacyStrobe,
  output var  lpc_irq_pkg::legacy_access_s legacyAccess,
  input  wire logic [7:0]                 legacyRdData
);
  localparam int NL = lpc_irq_pkg::NUM_LOCALITIES;

  // host link cycle state
  lpc_irq_pkg::lpc_state_e state_reg;
  lpc_irq_pkg::lpc_state_e state_next;
  logic [1:0]  cnt_reg;
  logic [1:0]  cnt_next;
  logic [3:0]  startNib_reg;
  logic        isLoc_reg;
  logic        isLoc_next;
  logic        isWrite_reg;
  logic        isWrite_next;
  logic [15:0] addr_reg;
  logic [15:0] addr_next;
  logic [7:0]  wdata_reg;
  logic [7:0]  wdata_next;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;

  // shared interrupt settings
  logic        master_reg;
  logic        cmdIdleEn_reg;
  logic        ownerSwEn_reg;
  logic        statusOkEn_reg;
  logic        responseEn_reg;
  logic [1:0]  trigger_reg;
  logic [3:0]  channel_reg;
  logic [7:0]  cause_reg;
  logic [7:0]  cause_next;
  logic        irqActive_reg;
  logic        irqActive_next;
  logic        masterChg_reg;

  // ownership
  logic [NL-1:0] pending_reg;
  logic [NL-1:0] pending_next;
  logic          ownerValid_next;
  logic [2:0]    owner_next;
  logic          ownerSwitchEvt;
  logic [2:0]    grantIdx;

  // previous flag levels for rise detection
  logic        cmdIdlePrev_reg;
  logic        statusOkPrev_reg;
  logic        responsePrev_reg;

  // decode wires
  logic [11:0] regOfs;
  logic [3:0]  locField;
  logic [2:0]  loc;
  logic        locHit;
  logic        legacyHit;
  logic        claimed;
  logic        regWrite;
  logic        wrOwn;
  logic        wrEnLow;
  logic        wrEnTop;
  logic        wrVector;
  logic        wrCause;
  logic        reqWr;
  logic        relWr;
  logic        masterChg;
  logic [7:0]  enLowByte;
  logic [7:0]  ownByte;
  logic [7:0]  regRead;
  logic [7:0]  enMask;
  logic [7:0]  causeSet;
  logic [7:0]  causeClr;
  logic        causeLive;
  lpc_irq_pkg::irq_cfg_s irqCfg;

  assign regOfs   = addr_reg[11:0];
  assign locField = addr_reg[15:lpc_irq_pkg::LOC_FIELD_LSB];
  assign loc      = locField[2:0];

  // locality cycles own the whole locality space of each locality
  assign locHit = isLoc_reg && locField < 4'(NL);
  assign legacyHit = LEGACY_EN && !isLoc_reg && !ownerValid &&
    addr_reg >= LEGACY_BASE &&
    addr_reg < LEGACY_BASE + 16'(lpc_irq_pkg::LEGACY_PORTS);
  assign claimed = locHit || legacyHit;

  // every locality address reaches the same register set
  assign regWrite = state_reg == lpc_irq_pkg::LPC_SYNC &&
                    isWrite_reg && locHit;
  assign wrOwn    = regWrite && regOfs == lpc_irq_pkg::OFS_OWNERSHIP;
  assign wrEnLow  = regWrite && regOfs == lpc_irq_pkg::OFS_IRQ_ENABLE;
  assign wrEnTop  = regWrite && regOfs == lpc_irq_pkg::OFS_IRQ_EN_TOP;
  assign wrVector = regWrite && regOfs == lpc_irq_pkg::OFS_IRQ_VECTOR;
  assign wrCause  = regWrite && regOfs == lpc_irq_pkg::OFS_IRQ_CAUSE;

  assign reqWr = wrOwn && wdata_reg[lpc_irq_pkg::OWN_REQUEST];
  assign relWr = wrOwn && wdata_reg[lpc_irq_pkg::OWN_ACTIVE] &&
                 ownerValid && currentOwner == loc;
  assign masterChg = wrEnTop &&
    (wdata_reg[lpc_irq_pkg::MASTER_BIT] != master_reg);

  // read views; reserved bits read zero
  assign enLowByte = {cmdIdleEn_reg, 2'b00, trigger_reg,
                      ownerSwEn_reg, statusOkEn_reg, responseEn_reg};
  assign ownByte = {2'b00,
                    ownerValid && currentOwner == loc, 2'b00,
                    pending_reg[loc], 2'b00};

  always_comb begin
    if (regOfs == lpc_irq_pkg::OFS_OWNERSHIP) begin
      regRead = ownByte;
    end else if (regOfs == lpc_irq_pkg::OFS_IRQ_ENABLE) begin
      regRead = enLowByte;
    end else if (regOfs == lpc_irq_pkg::OFS_IRQ_EN_TOP) begin
      regRead = {master_reg, 7'h00};
    end else if (regOfs > lpc_irq_pkg::OFS_IRQ_ENABLE &&
                 regOfs < lpc_irq_pkg::OFS_IRQ_EN_TOP) begin
      regRead = 8'h00;
    end else if (regOfs == lpc_irq_pkg::OFS_IRQ_VECTOR) begin
      regRead = {4'h0, channel_reg};
    end else if (regOfs >= lpc_irq_pkg::OFS_IRQ_CAUSE &&
                 regOfs <= lpc_irq_pkg::OFS_IRQ_CAUSE + 12'h003) begin
      regRead = (regOfs == lpc_irq_pkg::OFS_IRQ_CAUSE) ? cause_reg : 8'h00;
    end else begin
      regRead = lpc_irq_pkg::UNMAPPED_READ;
    end
  end

  // cycle framing; a low frame line aborts whatever is in flight
  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    isLoc_next   = isLoc_reg;
    isWrite_next = isWrite_reg;
    addr_next    = addr_reg;
    wdata_next   = wdata_reg;
    rdata_next   = rdata_reg;
    if (!lframeN) begin
      state_next = lpc_irq_pkg::LPC_START;
    end else begin
      case (state_reg)
        lpc_irq_pkg::LPC_START: begin
          state_next = lpc_irq_pkg::LPC_IDLE;
          if ((startNib_reg == lpc_irq_pkg::LOC_START ||
               startNib_reg == lpc_irq_pkg::IO_START) &&
              (ladIn == lpc_irq_pkg::CYC_IO_READ ||
               ladIn == lpc_irq_pkg::CYC_IO_WRITE)) begin
            state_next   = lpc_irq_pkg::LPC_ADDR;
            cnt_next     = 2'h0;
            isLoc_next   = startNib_reg == lpc_irq_pkg::LOC_START;
            isWrite_next = ladIn == lpc_irq_pkg::CYC_IO_WRITE;
          end
        end
        lpc_irq_pkg::LPC_ADDR: begin
          addr_next = {addr_reg[11:0], ladIn};
          cnt_next  = cnt_reg + 2'h1;
          if (cnt_reg == 2'h3) begin
            state_next = isWrite_reg ? lpc_irq_pkg::LPC_WDATA
                                     : lpc_irq_pkg::LPC_HTAR;
          end
        end
        lpc_irq_pkg::LPC_WDATA: begin
          // low nibble first
          if (cnt_reg == 2'h0) begin
            wdata_next = {wdata_reg[7:4], ladIn};
          end else begin
            wdata_next = {ladIn, wdata_reg[3:0]};
          end
          cnt_next = cnt_reg + 2'h1;
          if (cnt_reg == 2'h1) begin
            state_next = lpc_irq_pkg::LPC_HTAR;
            cnt_next   = 2'h0;
          end
        end
        lpc_irq_pkg::LPC_HTAR: begin
          cnt_next = cnt_reg + 2'h1;
          if (cnt_reg == 2'h1) begin
            // unclaimed cycles get no sync, so the host aborts them
            state_next = claimed ? lpc_irq_pkg::LPC_SYNC
                                 : lpc_irq_pkg::LPC_IDLE;
            rdata_next = legacyHit ? legacyRdData : regRead;
          end
        end
        lpc_irq_pkg::LPC_SYNC: begin
          cnt_next   = 2'h0;
          state_next = isWrite_reg ? lpc_irq_pkg::LPC_DTAR
                                   : lpc_irq_pkg::LPC_RDATA;
        end
        lpc_irq_pkg::LPC_RDATA: begin
          cnt_next = cnt_reg + 2'h1;
          if (cnt_reg == 2'h1) begin
            state_next = lpc_irq_pkg::LPC_DTAR;
          end
        end
        lpc_irq_pkg::LPC_DTAR: state_next = lpc_irq_pkg::LPC_IDLE;
        default: state_next = lpc_irq_pkg::LPC_IDLE;
      endcase
    end
  end

  // device drives sync, read data low nibble first, then one idle nibble
  always_comb begin
    ladOe  = 1'b1;
    ladOut = lpc_irq_pkg::TAR_IDLE;
    case (state_reg)
      lpc_irq_pkg::LPC_SYNC:  ladOut = lpc_irq_pkg::SYNC_READY;
      lpc_irq_pkg::LPC_RDATA: begin
        ladOut = (cnt_reg == 2'h0) ? rdata_reg[3:0] : rdata_reg[7:4];
      end
      lpc_irq_pkg::LPC_DTAR:  ladOut = lpc_irq_pkg::TAR_IDLE;
      default:                ladOe  = 1'b0;
    endcase
  end

  assign legacyStrobe = state_reg == lpc_irq_pkg::LPC_SYNC && !isLoc_reg;

  // highest waiting locality wins when ownership frees up
  always_comb begin
    grantIdx = 3'h0;
    for (int i = 0; i < NL; i++) begin
      if (pending_reg[i]) begin
        grantIdx = 3'(i);
      end
    end
  end

  always_comb begin
    pending_next    = pending_reg;
    ownerValid_next = ownerValid;
    owner_next      = currentOwner;
    ownerSwitchEvt  = 1'b0;
    if (relWr) begin
      ownerValid_next = 1'b0;
    end else if (reqWr && !ownerValid) begin
      ownerValid_next = 1'b1;
      owner_next      = loc;
    end else if (reqWr && currentOwner != loc) begin
      pending_next[loc] = 1'b1;
    end else if (!ownerValid && |pending_reg) begin
      ownerValid_next        = 1'b1;
      owner_next             = grantIdx;
      pending_next[grantIdx] = 1'b0;
      ownerSwitchEvt         = 1'b1;
    end
  end

  // cause events
  assign causeSet[lpc_irq_pkg::CAUSE_CMD_IDLE] =
    cmdIdleFlag && !cmdIdlePrev_reg;
  assign causeSet[lpc_irq_pkg::CAUSE_OWNER_SW] = ownerSwitchEvt;
  assign causeSet[lpc_irq_pkg::CAUSE_STATUS_OK] =
    statusOkFlag && !statusOkPrev_reg;
  assign causeSet[lpc_irq_pkg::CAUSE_RESPONSE] =
    responseReadyFlag && !responsePrev_reg && statusOkFlag;
  assign causeSet[6:3] = 4'h0;
  assign causeClr = wrCause ? wdata_reg : 8'h00;

  // a set in the clearing cycle survives the clear
  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_cause
      assign cause_next[b] = lpc_irq_pkg::CAUSE_MASK[b] &&
        ((cause_reg[b] && !causeClr[b]) || causeSet[b]);
    end
  endgenerate

  assign enMask = {cmdIdleEn_reg, 4'h0, ownerSwEn_reg,
                   statusOkEn_reg, responseEn_reg};
  assign causeLive = |(cause_reg & enMask);

  // one interrupt per EOI; flags left after it fire again next cycle
  always_comb begin
    irqActive_next = irqActive_reg;
    if (!master_reg || masterChg || masterChg_reg) begin
      irqActive_next = 1'b0;
    end else if (wrCause) begin
      irqActive_next = 1'b0;
    end else if (!irqActive_reg && causeLive) begin
      irqActive_next = 1'b1;
    end
  end

  assign irqPending = irqActive_reg && master_reg;
  assign irqCfg.serialIrqChannel = channel_reg;
  assign irqCfg.triggerTypeSel = lpc_irq_pkg::trigger_e'(trigger_reg);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= lpc_irq_pkg::LPC_IDLE;
      cnt_reg      <= 2'h0;
      startNib_reg <= 4'h0;
      isLoc_reg    <= 1'b0;
      isWrite_reg  <= 1'b0;
      addr_reg     <= 16'h0000;
      wdata_reg    <= 8'h00;
      rdata_reg    <= 8'h00;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      startNib_reg <= lframeN ? startNib_reg : ladIn;
      isLoc_reg    <= isLoc_next;
      isWrite_reg  <= isWrite_next;
      addr_reg     <= addr_next;
      wdata_reg    <= wdata_next;
      rdata_reg    <= rdata_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      master_reg     <= lpc_irq_pkg::ENABLE_RESET;
      cmdIdleEn_reg  <= lpc_irq_pkg::ENABLE_RESET;
      ownerSwEn_reg  <= lpc_irq_pkg::ENABLE_RESET;
      statusOkEn_reg <= lpc_irq_pkg::ENABLE_RESET;
      responseEn_reg <= lpc_irq_pkg::ENABLE_RESET;
      trigger_reg    <= lpc_irq_pkg::TRIGGER_RESET;
      channel_reg    <= lpc_irq_pkg::VECTOR_RESET;
    end else begin
      if (wrEnTop) begin
        master_reg <= wdata_reg[lpc_irq_pkg::MASTER_BIT];
      end
      if (wrEnLow) begin
        cmdIdleEn_reg  <= wdata_reg[lpc_irq_pkg::EN_CMD_IDLE];
        trigger_reg    <= wdata_reg[lpc_irq_pkg::TRIG_HI:
                                    lpc_irq_pkg::TRIG_LO];
        ownerSwEn_reg  <= wdata_reg[lpc_irq_pkg::EN_OWNER_SW];
        statusOkEn_reg <= wdata_reg[lpc_irq_pkg::EN_STATUS_OK];
        responseEn_reg <= wdata_reg[lpc_irq_pkg::EN_RESPONSE];
      end
      if (wrVector) begin
        channel_reg <= wdata_reg[3:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cause_reg        <= lpc_irq_pkg::CAUSE_RESET;
      irqActive_reg    <= 1'b0;
      masterChg_reg    <= 1'b0;
      pending_reg      <= '0;
      ownerValid       <= 1'b0;
      currentOwner     <= 3'h0;
      cmdIdlePrev_reg  <= 1'b0;
      statusOkPrev_reg <= 1'b0;
      responsePrev_reg <= 1'b0;
    end else begin
      cause_reg        <= cause_next;
      irqActive_reg    <= irqActive_next;
      masterChg_reg    <= masterChg;
      pending_reg      <= pending_next;
      ownerValid       <= ownerValid_next;
      currentOwner     <= owner_next;
      cmdIdlePrev_reg  <= cmdIdleFlag;
      statusOkPrev_reg <= statusOkFlag;
      responsePrev_reg <= responseReadyFlag;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      legacyAccess <= '0;
    end else if (state_reg == lpc_irq_pkg::LPC_HTAR && !isLoc_reg) begin
      legacyAccess <= '{write: isWrite_reg, addr: addr_reg,
                        data: wdata_reg};
    end
  end

  // the slot follower only sees the gated request
  serial_irq_slot u_slot (
    .clk       (clk),
    .rst_n     (rst_n),
    .serirqIn  (serirqIn),
    .serirqOut (serirqOut),
    .serirqOe  (serirqOe),
    .cfg       (irqCfg),
    .irqActive (irqPending)
  );
endmodule : lpc_locality_interrupt_unit
`default_nettype wire

// [lpc_irq_asserts.sv]
// port checks for the locality interrupt unit
`timescale 1ns/1ns
`default_nettype none
module lpc_irq_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic lframeN,
  input wire logic [3:0] ladOut,
  input wire logic ladOe,
  input wire logic serirqOut,
  input wire logic serirqOe,
  input wire logic ownerValid,
  input wire logic legacyStrobe,
  input wire lpc_irq_pkg::legacy_access_s legacyAccess
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_sync;
    ladOe && ladOut == 4'h0;
  endsequence
  a_strobe_one_cycle: assert property (legacyStrobe |=> !legacyStrobe)
    else $error("legacy strobe too long");
  a_legacy_no_owner: assert property (legacyStrobe |-> !ownerValid)
    else $error("legacy cycle claimed while owned");
  a_legacy_in_window: assert property (legacyStrobe |->
    (legacyAccess.addr - lpc_irq_pkg::LEGACY_BASE_DEFAULT) < 16'h0002)
    else $error("legacy claim outside window");
  a_sync_comes_first: assert property ($rose(ladOe) |-> s_sync)
    else $error("first driven nibble not ready sync");
  a_drive_two_cycles: assert property ($rose(ladOe) |=> ladOe)
    else $error("device drive too short");
  a_release_after_idle: assert property ($fell(ladOe) |->
    $past(ladOut) == 4'hF)
    else $error("release without idle nibble");
  a_drive_in_frame: assert property (ladOe |-> lframeN)
    else $error("device drives during frame start");
  a_recovery_drive_high: assert property (serirqOe && !serirqOut |=>
    serirqOe && serirqOut)
    else $error("no recovery drive after slot");
endmodule : lpc_irq_asserts
bind lpc_locality_interrupt_unit lpc_irq_asserts chk (.clk(clk),
  .rst_n(rst_n), .lframeN(lframeN), .ladOut(ladOut), .ladOe(ladOe),
  .serirqOut(serirqOut), .serirqOe(serirqOe), .ownerValid(ownerValid),
  .legacyStrobe(legacyStrobe), .legacyAccess(legacyAccess));
`default_nettype wire

// [lpc_host_model.sv]
// host bridge model: link cycles and serial irq frame starts
`timescale 1ns/1ns
`default_nettype none
module lpc_host_model (
  input  wire logic       clk,
  input  wire logic [3:0] devLad,
  input  wire logic       devOe,
  input  wire logic       serLine,
  output var  logic       lframeN,
  output var  logic [3:0] hostLad,
  output var  logic       serLow
);
  initial begin
    lframeN = 1'b1;
    hostLad = 4'hF;
    serLow = 1'b0;
  end
  // one byte per call, so wide accesses are split by the caller
  task cyc(input logic [3:0] st, input logic wr, input logic [15:0] a,
    input logic [7:0] d, output logic [7:0] q, output logic ok);
    int i;
    q = 8'h00;
    ok = 1'b0;
    @(posedge clk) #1 lframeN = 1'b0;
    hostLad = st;
    @(posedge clk) #1 lframeN = 1'b1;
    hostLad = wr ? 4'h2 : 4'h0;
    for (i = 3; i >= 0; i--) @(posedge clk) #1 hostLad = a[4*i+:4];
    if (wr) @(posedge clk) #1 hostLad = d[3:0];
    if (wr) @(posedge clk) #1 hostLad = d[7:4];
    // released lines float high through the pull-ups
    @(posedge clk) #1 hostLad = 4'hF;
    for (i = 0; i < 6 && !ok; i++) begin
      @(negedge clk);
      ok = devOe && devLad == 4'h0;
    end
    if (ok && !wr) begin
      @(negedge clk) q[3:0] = devLad;
      @(negedge clk) q[7:4] = devLad;
    end
    repeat (3) @(negedge clk);
  endtask : cyc
  task frame(output logic [47:0] seen);
    int i;
    @(posedge clk) #1 serLow = 1'b1;
    repeat (6) @(posedge clk);
    #1 serLow = 1'b0;
    for (i = 0; i < 48; i++) @(negedge clk) seen[i] = serLine;
  endtask : frame
endmodule : lpc_host_model
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the locality interrupt unit
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
  $display("mismatch %0t %h %h", $time, a, b); end end
module tb_top;
  logic clk, rst_n, cmdIdleFlag, statusOkFlag, responseReadyFlag;
  logic [3:0] ladOut, hostLad;
  logic ladOe, lframeN, serirqOut, serirqOe, serLow, ok;
  logic ownerValid, irqPending, legacyStrobe;
  logic [2:0] currentOwner;
  lpc_irq_pkg::legacy_access_s legacyAccess;
  logic [7:0] q;
  logic [47:0] seen;
  int n_fail = 0;
  int n_tests = 0;
  wire logic [3:0] ladIn = ladOe ? ladOut : hostLad;
  wire logic serLine = !(serLow | (serirqOe & !serirqOut));
  lpc_locality_interrupt_unit uut (.clk(clk), .rst_n(rst_n),
    .lframeN(lframeN), .ladIn(ladIn), .ladOut(ladOut), .ladOe(ladOe),
    .serirqIn(serLine), .serirqOut(serirqOut), .serirqOe(serirqOe),
    .cmdIdleFlag(cmdIdleFlag), .statusOkFlag(statusOkFlag),
    .responseReadyFlag(responseReadyFlag), .ownerValid(ownerValid),
    .currentOwner(currentOwner), .irqPending(irqPending),
    .legacyStrobe(legacyStrobe), .legacyAccess(legacyAccess),
    .legacyRdData(8'h5A));
  lpc_host_model host (.clk(clk), .devLad(ladOut), .devOe(ladOe),
    .serLine(serLine), .lframeN(lframeN), .hostLad(hostLad),
    .serLow(serLow));
  task wr(input logic [15:0] a, input logic [7:0] d);
    host.cyc(lpc_irq_pkg::LOC_START, 1'b1, a, d, q, ok);
  endtask : wr
  task rd(input logic [15:0] a);
    host.cyc(lpc_irq_pkg::LOC_START, 1'b0, a, 8'h00, q, ok);
  endtask : rd
  task io(input logic w, input logic [15:0] a, input logic [7:0] d);
    host.cyc(lpc_irq_pkg::IO_START, w, a, d, q, ok);
  endtask : io
  task t_regs;
    rd(16'h0008);
    `CHK(q, 8'h08)
    rd(16'h300B);
    `CHK(q, 8'h00)
    rd(16'h0010);
    `CHK(q, 8'h00)
    wr(16'h000C, 8'hFF);
    rd(16'h300C);
    `CHK(q, 8'h0F)
    wr(16'h0008, 8'hFF);
    rd(16'h0008);
    `CHK(q, 8'h9F)
    rd(16'h0030);
    `CHK(q, 8'hFF)
    rd(16'h5008);
    `CHK(ok, 1'b0)
    $display("regs done");
  endtask : t_regs
  task t_owner;
    wr(16'h0000, 8'h02);
    rd(16'h0000);
    `CHK(q & 8'h24, 8'h20)
    rd(16'h0010);
    `CHK(q, 8'h00)
    wr(16'h2000, 8'h02);
    io(1'b0, 16'h004E, 8'h00);
    `CHK(ok, 1'b0)
    wr(16'h0000, 8'h20);
    rd(16'h2000);
    `CHK(q & 8'h24, 8'h20)
    `CHK(currentOwner, 3'h2)
    wr(16'h1010, 8'h00);
    rd(16'h1010);
    `CHK(q, 8'h04)
    wr(16'h0010, 8'h04);
    rd(16'h0010);
    `CHK(q, 8'h00)
    wr(16'h2000, 8'h20);
    io(1'b1, 16'h004F, 8'hA5);
    `CHK(legacyAccess, {1'b1, 16'h004F, 8'hA5})
    io(1'b0, 16'h004E, 8'h00);
    `CHK(q, 8'h5A)
    $display("owner done");
  endtask : t_owner
  task t_irq;
    wr(16'h0008, 8'h89);
    wr(16'h000B, 8'h80);
    @(posedge clk) #1 cmdIdleFlag = 1'b1;
    @(posedge clk) #1 statusOkFlag = 1'b1;
    @(posedge clk) #1 responseReadyFlag = 1'b1;
    repeat (3) @(negedge clk);
    `CHK(irqPending, 1'b1)
    rd(16'h0010);
    `CHK(q, 8'h83)
    wr(16'h0010, 8'h80);
    `CHK(irqPending, 1'b1)
    wr(16'h000C, 8'h00);
    host.frame(seen);
    `CHK(&seen, 1'b1)
    wr(16'h000C, 8'h03);
    host.frame(seen);
    `CHK(&seen[9:0], 1'b1)
    `CHK(&seen[12:10], 1'b0)
    wr(16'h0008, 8'h81);
    host.frame(seen);
    `CHK(&seen[12:10], 1'b1)
    wr(16'h0010, 8'h03);
    `CHK(irqPending, 1'b0)
    @(posedge clk) #1 cmdIdleFlag = 1'b0;
    @(posedge clk) #1 cmdIdleFlag = 1'b1;
    repeat (3) @(negedge clk);
    `CHK(irqPending, 1'b1)
    wr(16'h000B, 8'h00);
    `CHK(irqPending, 1'b0)
    $display("irq done");
  endtask : t_irq
  task end_sim;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    cmdIdleFlag = 1'b0;
    statusOkFlag = 1'b0;
    responseReadyFlag = 1'b0;
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    t_regs;
    t_owner;
    t_irq;
    end_sim;
  end
  // about 650 cycles expected; over four times that means a hang
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    end_sim;
  end
endmodule : tb_top
`default_nettype wire
